// ===== rtl/port_handshake.sv
// Handshake control of a two-port peripheral adapter on an 8-bit bus.
// Assumes all inputs are asynchronous pins sampled on the 25 MHz CLOCK,
// and that the enable clock phases last several CLOCK periods.
// Contract
// R1: An active port A strobe edge means input data ready; request interrupt.
// R2: The peripheral holds port A data stable until the processor reads it.
// R3: A processor read of port A drives the port A reply line low.
// R4: An active port A strobe edge drives the port A reply line high.
// R5: A pending data-ready condition drives the interrupt request output low.
// R6: A port A read puts peripheral input data onto the processor bus.
// R7: The processor gives address and write level, then data during phase two.
// R8: Write data is latched on the falling edge of the enable clock.
// R9: A port B write starts the handshake by signalling data available.
// R10: The peripheral acknowledges port B data with a port B strobe edge.
// R11: The port B strobe acknowledge drives the port B reply line high.
// R12: Respond only when first and second selects high and third low.
// R13: In handshake mode the port B reply line goes low on each port B write.
// R14: The port B reply line stays low until the port B strobe acknowledge.
// R15: A port A flag sets on strobe and clears on port A data read.
`timescale 1ns/100ps
module port_handshake
  import port_hs_pkg::*;
(
  // Clock and reset
  input wire logic CLOCK,
  input wire logic ARST_N,
  // Processor bus
  input wire logic ENABLE_CLK,
  input wire logic READ_WRITE,
  input wire logic REG_SELECT,
  input wire logic CHIP_SELECT_FIRST_HIGH,
  input wire logic CHIP_SELECT_SECOND_HIGH,
  input wire logic CHIP_SELECT_THIRD_LOW,
  input wire logic [port_hs_pkg::DATA_W-1:0] BUS_DATA_IN,
  output logic [port_hs_pkg::DATA_W-1:0] BUS_DATA_OUT,
  output logic BUS_DATA_OE_N,
  output logic IRQ_N,
  // Static configuration
  input wire logic A_STROBE_RISING,
  input wire logic B_STROBE_RISING,
  input wire logic B_HANDSHAKE_EN,
  // Port A, peripheral to processor
  input wire logic [port_hs_pkg::DATA_W-1:0] PORT_A_IN,
  input wire logic PORT_A_STROBE_IN,
  output logic PORT_A_REPLY_LINE,
  // Port B, processor to peripheral
  output logic [port_hs_pkg::DATA_W-1:0] PORT_B_OUT,
  input wire logic PORT_B_STROBE_IN,
  output logic PORT_B_REPLY_LINE
);
  import port_hs_pkg::*;

  logic [BUS_SYNC_W-1:0] bus_pins;
  logic [BUS_SYNC_W-1:0] bus_s;
  logic [DATA_W-1:0] pa_s;
  logic [4:0] misc_s;
  logic en_s, rw_s, rs_s, cs1_s, cs2_s, cs3_s;
  logic [DATA_W-1:0] din_s;
  logic a_stb_s, b_stb_s, a_rise_s, b_rise_s, b_hs_s;
  logic en_prev_r, a_stb_prev_r, b_stb_prev_r;
  logic selected, enable_fall, write_ev, read_a_ev, rd_drive;
  logic a_edge, b_edge;
  logic a_flag_r, a_flag_nxt;
  logic a_reply_r, a_reply_nxt;
  logic b_reply_r, b_reply_nxt;
  logic [DATA_W-1:0] pb_r, pb_nxt;
  logic [DATA_W-1:0] dout_r, dout_nxt;
  logic oe_n_r;
  logic irq_n_r;
  logic is_write, is_read, sel_port_a, sel_port_b;
  logic a_rise_ev, a_fall_ev, b_rise_ev, b_fall_ev;
  logic [DATA_W-1:0] dout_sel;

  // Strobe pins, polarity pins and the handshake mode pin share one synchroniser
  localparam int MISC_W = 5;

  assign bus_pins = {ENABLE_CLK, READ_WRITE, REG_SELECT,
                     CHIP_SELECT_FIRST_HIGH, CHIP_SELECT_SECOND_HIGH,
                     CHIP_SELECT_THIRD_LOW, BUS_DATA_IN};

  // Bus pins, port A data and handshake pins each pass two flops
  sync_cell #(.WIDTH(BUS_SYNC_W)) u_bus_sync (
    .clk(CLOCK),
    .arst_n(ARST_N),
    .pin_in(bus_pins),
    .sync_out(bus_s)
  );
  sync_cell #(.WIDTH(DATA_W)) u_pa_sync (
    .clk(CLOCK),
    .arst_n(ARST_N),
    .pin_in(PORT_A_IN),
    .sync_out(pa_s)
  );
  sync_cell #(.WIDTH(MISC_W)) u_misc_sync (
    .clk(CLOCK),
    .arst_n(ARST_N),
    .pin_in({PORT_A_STROBE_IN, PORT_B_STROBE_IN, A_STROBE_RISING,
             B_STROBE_RISING, B_HANDSHAKE_EN}),
    .sync_out(misc_s)
  );

  assign {en_s, rw_s, rs_s, cs1_s, cs2_s, cs3_s, din_s} = bus_s;
  assign {a_stb_s, b_stb_s, a_rise_s, b_rise_s, b_hs_s} = misc_s;

  // Decode
  assign selected = cs1_s & cs2_s & ~cs3_s; // R12
  assign is_write = (rw_s == RW_WRITE);
  assign is_read = (rw_s == RW_READ);
  assign sel_port_a = (rs_s == SEL_PORT_A);
  assign sel_port_b = (rs_s == SEL_PORT_B);
  assign enable_fall = en_prev_r & ~en_s;
  // Data is taken as the enable clock falls, while still driven
  assign write_ev = enable_fall & selected & is_write & sel_port_b; // R8
  // A port A read only counts once the access completes
  assign read_a_ev = enable_fall & selected & is_read & sel_port_a; // R3
  // Drive lasts the whole phase so a slow processor still sees data
  assign rd_drive = en_s & selected & is_read; // R6

  // Both edges are decoded; the polarity pin picks the active one
  assign a_rise_ev = a_stb_s & ~a_stb_prev_r;
  assign a_fall_ev = ~a_stb_s & a_stb_prev_r;
  assign b_rise_ev = b_stb_s & ~b_stb_prev_r;
  assign b_fall_ev = ~b_stb_s & b_stb_prev_r;
  assign a_edge = a_rise_s ? a_rise_ev : a_fall_ev;
  assign b_edge = b_rise_s ? b_rise_ev : b_fall_ev; // R11

  // A strobe arriving with the clearing read keeps the flag set
  assign a_flag_nxt = a_edge ? 1'h1 // R1 R15
                    : (read_a_ev ? 1'h0 : a_flag_r);
  // New data wins over the read so the peripheral is never told twice
  assign a_reply_nxt = a_edge ? 1'h1 // R4
                     : (read_a_ev ? 1'h0 : a_reply_r); // R3
  // Port B data holds in this register until the next accepted write
  assign pb_nxt = write_ev ? din_s : pb_r; // R8
  // A write landing with a stale acknowledge still signals new data
  assign b_reply_nxt = (write_ev & b_hs_s) ? 1'h0 // R9 R13
                     : (b_edge ? 1'h1 : b_reply_r); // R11 R14
  // Port A read returns live peripheral data; port B reads back its latch
  assign dout_sel = sel_port_a ? pa_s : pb_r; // R6
  assign dout_nxt = rd_drive ? dout_sel : BUS_IDLE;

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      en_prev_r <= 1'h0;
      a_stb_prev_r <= 1'h0;
      b_stb_prev_r <= 1'h0;
    end else begin
      en_prev_r <= en_s;
      a_stb_prev_r <= a_stb_s;
      b_stb_prev_r <= b_stb_s;
    end
  end

  // Port A handshake state
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      a_flag_r <= 1'h0;
      a_reply_r <= REPLY_RESET;
    end else begin
      a_flag_r <= a_flag_nxt;
      a_reply_r <= a_reply_nxt;
    end
  end

  // Port B data latch and handshake state
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      b_reply_r <= REPLY_RESET;
      pb_r <= PORT_B_RESET;
    end else begin
      b_reply_r <= b_reply_nxt;
      pb_r <= pb_nxt;
    end
  end

  // Read path; the bus is let go one clock after the access ends
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      dout_r <= BUS_IDLE;
      oe_n_r <= OE_N_RESET;
    end else begin
      dout_r <= dout_nxt;
      oe_n_r <= ~rd_drive;
    end
  end

  // Taken from the next flag value so it moves with the reply line
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      irq_n_r <= IRQ_N_RESET;
    end else begin
      irq_n_r <= ~a_flag_nxt; // R5
    end
  end

  assign BUS_DATA_OUT = dout_r;
  assign BUS_DATA_OE_N = oe_n_r;
  assign IRQ_N = irq_n_r;
  assign PORT_A_REPLY_LINE = a_reply_r;
  assign PORT_B_OUT = pb_r;
  assign PORT_B_REPLY_LINE = b_reply_r;
endmodule : port_handshake

// ===== rtl/port_hs_pkg.sv
// Shared constants for the peripheral port handshake block.
// Assumes an 8-bit processor bus and one 25 MHz system clock.
package port_hs_pkg;
  localparam int DATA_W = 8;
  localparam int SYNC_STAGES = 2;
  // Register select values seen on the select pin
  localparam logic SEL_PORT_A = 1'h0;
  localparam logic SEL_PORT_B = 1'h1;
  // Reset values
  localparam logic [DATA_W-1:0] PORT_B_RESET = 8'h00;
  localparam logic [DATA_W-1:0] BUS_IDLE = 8'h00;
  localparam logic REPLY_RESET = 1'h1;
  localparam logic IRQ_N_RESET = 1'h1;
  localparam logic OE_N_RESET = 1'h1;
  // Bus direction encoding
  localparam logic RW_WRITE = 1'h0;
  localparam logic RW_READ = 1'h1;
  // Width of the bundled bus-side synchroniser
  localparam int BUS_SYNC_W = DATA_W + 6;
endpackage : port_hs_pkg

// ===== rtl/sync_cell.sv
// Two flip-flop synchroniser for a group of slowly changing pins.
// Assumes each bit is stable for several clocks around the sampling point.
`timescale 1ns/100ps
module sync_cell #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Pins and their synchronised copies
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_r <= '0;
      sync_out <= '0;
    end else begin
      meta_r <= pin_in;
      sync_out <= meta_r;
    end
  end
endmodule : sync_cell

// ===== tb/port_hs_checker.sv
// Pin assertions for the port handshake block.
// Assumes rising-edge strobes; the port B write reply check follows the handshake mode pin.
`timescale 1ns/100ps
module port_hs_checker (
  input wire logic CLOCK, ARST_N, ENABLE_CLK, READ_WRITE, REG_SELECT,
  input wire logic CHIP_SELECT_FIRST_HIGH, CHIP_SELECT_SECOND_HIGH,
  input wire logic CHIP_SELECT_THIRD_LOW, BUS_DATA_OE_N, IRQ_N,
  input wire logic PORT_A_STROBE_IN, PORT_A_REPLY_LINE,
  input wire logic PORT_B_STROBE_IN, PORT_B_REPLY_LINE, B_HANDSHAKE_EN,
  input wire logic [7:0] BUS_DATA_IN, BUS_DATA_OUT, PORT_A_IN, PORT_B_OUT
);
  wire sel = CHIP_SELECT_FIRST_HIGH && CHIP_SELECT_SECOND_HIGH
    && !CHIP_SELECT_THIRD_LOW;
  wire rd_a = sel && READ_WRITE && !REG_SELECT;
  wire wr_b = sel && !READ_WRITE && REG_SELECT;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!ARST_N);
  a_strobe_irq: assert property ($rose(PORT_A_STROBE_IN) |->
    ##[2:6] !IRQ_N && PORT_A_REPLY_LINE) else $error("no ready");
  a_read_reply: assert property ($fell(ENABLE_CLK) && rd_a |->
    ##[2:6] !PORT_A_REPLY_LINE && IRQ_N) else $error("read not taken");
  a_read_data: assert property (ENABLE_CLK && rd_a && $past(rd_a, 3) &&
    !BUS_DATA_OE_N |-> BUS_DATA_OUT == PORT_A_IN) else $error("bad data");
  a_write_latch: assert property ($fell(ENABLE_CLK) && wr_b |->
    ##[2:5] PORT_B_OUT == BUS_DATA_IN) else $error("no latch");
  a_write_reply: assert property ($fell(ENABLE_CLK) && wr_b &&
    B_HANDSHAKE_EN |->
    ##[2:5] !PORT_B_REPLY_LINE) else $error("no reply low");
  a_ack_reply: assert property ($rose(PORT_B_STROBE_IN) |->
    ##[2:6] PORT_B_REPLY_LINE) else $error("no ack");
  a_reply_hold: assert property ($rose(PORT_B_REPLY_LINE) |->
    $past(PORT_B_STROBE_IN, 2) != $past(PORT_B_STROBE_IN, 6)) else
    $error("early reply");
  a_select_gate: assert property (!sel [*8] |->
    BUS_DATA_OE_N && $stable(PORT_B_OUT)) else $error("unselected");
  c_irq: cover property ($fell(IRQ_N));
  c_b_low: cover property ($fell(PORT_B_REPLY_LINE));
  c_read: cover property ($fell(BUS_DATA_OE_N));
endmodule : port_hs_checker

bind port_handshake port_hs_checker chk (.*);

// ===== tb/periph_model.sv
// Peripheral model: offers port A bytes, takes port B bytes.
// Assumes rising-edge strobes; b_wait sets how slowly port B is acked.
`timescale 1ns/100ps
module periph_model (
  input wire logic CLOCK, a_go, PORT_A_REPLY_LINE, PORT_B_REPLY_LINE,
  input wire logic [7:0] a_byte, PORT_B_OUT,
  input wire logic [3:0] b_wait,
  output logic [7:0] b_got, PORT_A_IN,
  output logic PORT_A_STROBE_IN, PORT_B_STROBE_IN
);
  logic [3:0] n;
  logic a_up;
  initial {b_got, PORT_A_IN, PORT_A_STROBE_IN, PORT_B_STROBE_IN, n, a_up} = '0;
  always @(posedge CLOCK) begin
    a_up <= a_go ? 1'b0 : a_up | PORT_A_REPLY_LINE;
    if (a_go) {PORT_A_IN, PORT_A_STROBE_IN} <= {a_byte, 1'b1};
    // Released data toggles each cycle so a stale byte never passes
    else if (a_up && !PORT_A_REPLY_LINE)
      {PORT_A_IN, PORT_A_STROBE_IN} <= {~PORT_A_IN, 1'b0};
    n <= PORT_B_REPLY_LINE ? 4'h0 : n + {3'h0, n != b_wait};
    PORT_B_STROBE_IN <= !PORT_B_REPLY_LINE && n == b_wait;
    if (!PORT_B_REPLY_LINE && n == b_wait) b_got <= PORT_B_OUT;
  end
endmodule : periph_model

// ===== tb/tb_top.sv
// Bench: bus tasks on one side, peripheral model on the other.
// Assumes rising-edge strobes; one scenario turns handshake mode off.
`timescale 1ns/100ps
module tb_top;
  import port_hs_pkg::*;
  logic CLOCK, ARST_N, ENABLE_CLK, READ_WRITE, REG_SELECT, BUS_DATA_OE_N;
  logic CHIP_SELECT_FIRST_HIGH, CHIP_SELECT_SECOND_HIGH, CHIP_SELECT_THIRD_LOW;
  logic IRQ_N, A_STROBE_RISING, B_STROBE_RISING, B_HANDSHAKE_EN, a_go;
  logic PORT_A_STROBE_IN, PORT_A_REPLY_LINE, PORT_B_STROBE_IN;
  logic PORT_B_REPLY_LINE;
  logic [DATA_W-1:0] BUS_DATA_IN, BUS_DATA_OUT, PORT_A_IN, PORT_B_OUT;
  logic [7:0] a_byte, b_got, rd;
  logic [3:0] b_wait;
  logic [2:0] cs;
  int n_errors, cmp_count;
  wire [1:0] mon = {IRQ_N, PORT_B_REPLY_LINE};
  assign {CHIP_SELECT_FIRST_HIGH, CHIP_SELECT_SECOND_HIGH,
    CHIP_SELECT_THIRD_LOW} = cs;
  port_handshake DUT (.*);
  periph_model peer (.*);
  initial begin
    CLOCK = 1'b0;
    forever #20 CLOCK = ~CLOCK;
  end
  task print_verdict;
    $display("errors %0d of %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict
  task chk(input logic [7:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL %0t %h %h", $time, got, exp);
    end
  endtask : chk
  task wait_lvl(input int k, input logic v);
    for (int i = 0; i < 40 && mon[k] !== v; i++) @(negedge CLOCK);
    if (mon[k] !== v) begin
      n_errors++;
      print_verdict();
    end
  endtask : wait_lvl
  task bus(input logic rw, rs, input logic [2:0] c, input logic [7:0] d);
    @(posedge CLOCK);
    {ENABLE_CLK, READ_WRITE, REG_SELECT, cs} <= {1'b1, rw, rs, c};
    BUS_DATA_IN <= d;
    repeat (6) @(posedge CLOCK);
    @(negedge CLOCK) rd = BUS_DATA_OUT;
    @(posedge CLOCK) ENABLE_CLK <= 1'b0;
    repeat (6) @(posedge CLOCK);
    cs <= 3'h0;
    @(negedge CLOCK);
  endtask : bus
  task t_port_a;
    @(posedge CLOCK);
    {a_byte, a_go} <= {8'hA5, 1'b1};
    @(posedge CLOCK) a_go <= 1'b0;
    wait_lvl(1, 1'b0);
    chk({7'h00, PORT_A_REPLY_LINE}, 8'h01);
    bus(1'b1, 1'b0, 3'h6, 8'h00);
    chk(rd, 8'hA5);
    chk({6'h00, IRQ_N, PORT_A_REPLY_LINE}, 8'h02);
  endtask : t_port_a
  task t_port_b(input logic [7:0] d, input logic [3:0] w);
    b_wait = w;
    bus(1'b0, 1'b1, 3'h6, d);
    chk(PORT_B_OUT, d);
    if (w > 4'h8) chk({7'h00, PORT_B_REPLY_LINE}, 8'h00);
    wait_lvl(0, 1'b1);
    chk(b_got, d);
  endtask : t_port_b
  task t_refuse;
    for (int i = 0; i < 3; i++) begin
      bus(1'b0, 1'b1, 3'h6 ^ (3'h1 << i), 8'h00);
      chk(PORT_B_OUT, 8'hC3);
    end
  endtask : t_refuse
  task t_no_hs;
    @(posedge CLOCK) B_HANDSHAKE_EN <= 1'b0;
    repeat (4) @(posedge CLOCK);
    bus(1'b0, 1'b1, 3'h6, 8'h5A);
    chk(PORT_B_OUT, 8'h5A);
    chk({7'h00, PORT_B_REPLY_LINE}, 8'h01);
    @(posedge CLOCK) B_HANDSHAKE_EN <= 1'b1;
  endtask : t_no_hs
  initial begin
    {ARST_N, ENABLE_CLK, READ_WRITE, REG_SELECT, a_go, cs} = '0;
    {BUS_DATA_IN, a_byte, b_wait, n_errors, cmp_count} = '0;
    {A_STROBE_RISING, B_STROBE_RISING, B_HANDSHAKE_EN} = 3'h7;
    repeat (4) @(posedge CLOCK);
    ARST_N <= 1'b1;
    repeat (4) @(posedge CLOCK);
    t_port_a();
    t_port_b(8'h3C, 4'hC);
    t_port_b(8'hC3, 4'h0);
    t_refuse();
    t_no_hs();
    print_verdict();
  end
endmodule : tb_top
